// file: src/lsbc_params.svh
// Purpose: constants for the led sink blink control block
// Assumes: 25 MHz system clock
// Notes: offsets are register addresses on the serial register port
`ifndef LSBC_PARAMS_SVH
`define LSBC_PARAMS_SVH
`define LSBC_ADDR_FADE_LAW    8'h0F
`define LSBC_ADDR_ENABLES     8'h10
`define LSBC_ADDR_TIMES_UPPER 8'h11
`define LSBC_ADDR_TIMES_LOWER 8'h12
`define LSBC_RST_FADE_LAW     8'h00
`define LSBC_RST_ENABLES      8'h00
`define LSBC_RST_TIMES        8'h00
`define LSBC_LAW_MASK         8'h03
`define LSBC_EN_MASK          8'h7F
`define LSBC_ON_LSB           6
`define LSBC_CLK_HZ           25000000
`define LSBC_TICK_MS          100
`define LSBC_TICK_CYCLES      ((`LSBC_CLK_HZ / 1000) * `LSBC_TICK_MS)
`define LSBC_ON_T0            5'd2
`define LSBC_ON_T1            5'd6
`define LSBC_ON_T2            5'd8
`define LSBC_ON_T3            5'd12
`define LSBC_OFF_T1           5'd6
`define LSBC_OFF_T2           5'd12
`define LSBC_OFF_T3           5'd18
`endif

// file: src/lsbc_pkg.sv
// Purpose: types for the led sink blink control block
// Assumes: nothing
// Notes: law encoding follows the two-bit law field
package lsbc_pkg;
	typedef enum logic [1:0]
	{
		LSBC_LAW_LINEAR  = 2'h0,
		LSBC_LAW_SQUARE  = 2'h1,
		LSBC_LAW_CUBIC_A = 2'h2,
		LSBC_LAW_CUBIC_B = 2'h3
	} lsbc_law_type;
	typedef enum logic [1:0]
	{
		LSBC_ST_IDLE = 2'h0,
		LSBC_ST_ON   = 2'h1,
		LSBC_ST_OFF  = 2'h3
	} lsbc_sink_state_type;
endpackage : lsbc_pkg

// file: src/lsbc_sink_seq.sv
// Purpose: blink sequencer for one current sink
// Assumes: tick is a one-cycle pulse on clk
// Notes: durations are counted in ticks
`timescale 1ns/1ps
`include "lsbc_params.svh"
module lsbc_sink_seq
	import lsbc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       clk_en,
	input  wire logic       tick,
	input  wire logic       enable,
	input  wire logic [1:0] off_sel,
	input  wire logic [1:0] on_sel,
	output logic            sink_on
);
	typedef struct packed
	{
		lsbc_sink_state_type st;
		logic [4:0]          cnt;
		logic                on;
	} lsbc_seq_type;

	lsbc_seq_type s_r;
	lsbc_seq_type s_nxt;
	logic [4:0]   on_len;
	logic [4:0]   off_len;

	always_comb
	begin
		case (on_sel)
			2'h0: on_len = `LSBC_ON_T0;
			2'h1: on_len = `LSBC_ON_T1;
			2'h2: on_len = `LSBC_ON_T2;
			default: on_len = `LSBC_ON_T3;
		endcase
		case (off_sel)
			2'h1: off_len = `LSBC_OFF_T1;
			2'h2: off_len = `LSBC_OFF_T2;
			default: off_len = `LSBC_OFF_T3;
		endcase
	end

	always_comb
	begin
		s_nxt = s_r;
		if (!enable)
		begin
			s_nxt.st = LSBC_ST_IDLE;
			s_nxt.cnt = 5'h00;
			s_nxt.on = 1'b0;
		end
		else if (off_sel == 2'h0)
		begin
			s_nxt.st = LSBC_ST_ON; // R7
			s_nxt.cnt = 5'h00;
			s_nxt.on = 1'b1;
		end
		else
		begin
			case (s_r.st)
				LSBC_ST_IDLE:
				begin
					s_nxt.st = LSBC_ST_ON;
					s_nxt.cnt = 5'h00;
					s_nxt.on = 1'b1;
				end
				LSBC_ST_ON:
				begin
					s_nxt.on = 1'b1;
					if (tick)
					begin
						if (s_r.cnt + 5'h01 >= on_len) // R5 R11
						begin
							s_nxt.st = LSBC_ST_OFF;
							s_nxt.cnt = 5'h00;
							s_nxt.on = 1'b0;
						end
						else
							s_nxt.cnt = s_r.cnt + 5'h01;
					end
				end
				LSBC_ST_OFF:
				begin
					s_nxt.on = 1'b0;
					if (tick)
					begin
						if (s_r.cnt + 5'h01 >= off_len) // R8 R6
						begin
							s_nxt.st = LSBC_ST_ON;
							s_nxt.cnt = 5'h00;
							s_nxt.on = 1'b1;
						end
						else
							s_nxt.cnt = s_r.cnt + 5'h01;
					end
				end
				default:
				begin
					s_nxt.st = LSBC_ST_IDLE;
					s_nxt.cnt = 5'h00;
					s_nxt.on = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			s_r <= '{LSBC_ST_IDLE, 5'h00, 1'b0};
		else if (clk_en)
			s_r <= s_nxt;
	end

	assign sink_on = s_r.on;
endmodule : lsbc_sink_seq

// file: src/lsbc_top.sv
// Purpose: seven-channel led current sink enable, fade law select and blink sequencing
// Assumes: register port is a simple synchronous byte write/read port fed by the serial interface logic
// Notes: one shared timebase tick drives all sinks
// Summary of operation
// R1: the law register low two bits choose linear, square, or one of two square laws with varying dwell.
// R2: the two cubic laws use square-law codes with a per-code dwell that changes along the fade.
// R3: enable bits 0 to 6 switch sinks 1 to 7 on or off and bit 7 is reserved.
// R4: timing register bits 7:6 pick a shared on time of 0.2, 0.6, 0.8 or 1.2 s.
// R5: the on time applies only to enabled sinks with a nonzero off time, after which the sink turns off.
// R6: each two-bit off time field means disabled, 0.6, 1.2 or 1.8 s.
// R7: an enabled sink with off time 00 stays on steadily.
// R8: an enabled sink with nonzero off time alternates off for its off time and on for the on time.
// R9: the upper timing register holds sink 7, 6 and 5 off times in bits 5:4, 3:2 and 1:0.
// R10: the lower timing register holds sink 4, 3, 2 and 1 off times in bits 7:6, 5:4, 3:2 and 1:0.
// R11: every interval is a whole number of shared timebase ticks counted per sink.
// R12: reserved law and enable bits read as zero and writes to them do nothing.
`timescale 1ns/1ps
`include "lsbc_params.svh"
module lsbc_top
	import lsbc_pkg::*;
#(
	parameter int TICK_CYCLES = `LSBC_TICK_CYCLES
)
(
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       clk_en,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	output logic      [6:0] sink_on,
	output lsbc_law_type    fade_law_select,
	output logic            fade_square_dac,
	output logic      [1:0] fade_dwell_profile
);
	typedef struct packed
	{
		logic [1:0]  law;
		logic [6:0]  en;
		logic [7:0]  t_up;
		logic [7:0]  t_lo;
		logic [31:0] div;
		logic        tick;
		logic [7:0]  rdata;
	} lsbc_top_type;

	lsbc_top_type r_r;
	lsbc_top_type r_nxt;
	logic [13:0]  off_all;

	always_comb
	begin
		r_nxt = r_r;
		r_nxt.tick = 1'b0;
		if (r_r.div >= 32'(TICK_CYCLES - 1)) // R11
		begin
			r_nxt.div = 32'h0;
			r_nxt.tick = 1'b1;
		end
		else
			r_nxt.div = r_r.div + 32'h1;
		if (reg_wr)
		begin
			case (reg_addr)
				`LSBC_ADDR_FADE_LAW: r_nxt.law = reg_wdata[1:0]; // R1 R12
				`LSBC_ADDR_ENABLES: r_nxt.en = reg_wdata[6:0]; // R3 R12
				`LSBC_ADDR_TIMES_UPPER: r_nxt.t_up = reg_wdata; // R9
				`LSBC_ADDR_TIMES_LOWER: r_nxt.t_lo = reg_wdata; // R10
				default: r_nxt.law = r_r.law;
			endcase
		end
		case (reg_addr)
			`LSBC_ADDR_FADE_LAW: r_nxt.rdata = {6'h00, r_r.law}; // R12
			`LSBC_ADDR_ENABLES: r_nxt.rdata = {1'b0, r_r.en}; // R12
			`LSBC_ADDR_TIMES_UPPER: r_nxt.rdata = r_r.t_up;
			`LSBC_ADDR_TIMES_LOWER: r_nxt.rdata = r_r.t_lo;
			default: r_nxt.rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			r_r <= '{2'h0, 7'h00, 8'h00, 8'h00, 32'h0, 1'b0, 8'h00};
		else if (clk_en)
			r_r <= r_nxt;
	end

	// off fields packed sink 1 first
	assign off_all = {r_r.t_up[5:0], r_r.t_lo}; // R9 R10

	genvar g;
	generate
		for (g = 0; g < 7; g++)
		begin : g_sink
			lsbc_sink_seq u_seq
			(
				.clk     (clk),
				.sys_rst (sys_rst),
				.clk_en  (clk_en),
				.tick    (r_r.tick),
				.enable  (r_r.en[g]), // R3
				.off_sel (off_all[2*g +: 2]), // R6
				.on_sel  (r_r.t_up[`LSBC_ON_LSB +: 2]), // R4
				.sink_on (sink_on[g])
			);
		end
	endgenerate

	assign reg_rdata = r_r.rdata;
	assign fade_law_select = lsbc_law_type'(r_r.law); // R1
	assign fade_square_dac = (r_r.law != 2'h0); // R1 R2
	// 0 uniform dwell, 2/3 select the varying-dwell profiles
	assign fade_dwell_profile = r_r.law[1] ? r_r.law : 2'h0; // R2
endmodule : lsbc_top

// file: bench/lsbc_sva.sv
// Purpose: port assertions for lsbc_top
// Assumes: one clock domain
// Notes: bound into every lsbc_top
`timescale 1ns/1ps
`include "lsbc_params.svh"
module lsbc_sva
	import lsbc_pkg::*;
#(parameter int TICK_CYCLES = `LSBC_TICK_CYCLES)
(
	input wire logic         clk,
	input wire logic         sys_rst,
	input wire logic         clk_en,
	input wire logic         reg_wr,
	input wire logic [7:0]   reg_addr,
	input wire logic [7:0]   reg_wdata,
	input wire logic [7:0]   reg_rdata,
	input wire logic [6:0]   sink_on,
	input wire lsbc_law_type fade_law_select,
	input wire logic         fade_square_dac,
	input wire logic [1:0]   fade_dwell_profile
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_sq; fade_square_dac == (fade_law_select != 2'h0); endproperty
	a_sq: assert property (p_sq) else $error("square flag");
	property p_dw; fade_dwell_profile == (fade_law_select[1] ? fade_law_select : 2'h0); endproperty
	a_dw: assert property (p_dw) else $error("dwell");
	property p_law; reg_wr && clk_en && reg_addr == 8'h0F |-> ##2 fade_law_select == $past(reg_wdata[1:0], 2); endproperty
	a_law: assert property (p_law) else $error("law");
	property p_off; reg_wr && clk_en && reg_addr == 8'h10 |-> ##2 (sink_on & ~$past(reg_wdata[6:0], 2)) == 7'h00; endproperty
	a_off: assert property (p_off) else $error("sink off");
	property p_rsv; clk_en && reg_addr == 8'h0F |=> reg_rdata[7:2] == 6'h00; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved");
	property p_unm; clk_en && (reg_addr < 8'h0F || reg_addr > 8'h12) |=> reg_rdata == 8'h00; endproperty
	a_unm: assert property (p_unm) else $error("unmapped");
	property p_gap; $fell(sink_on[0]) |=> !sink_on[0] [*8]; endproperty
	a_gap: assert property (p_gap) else $error("short off");
	property p_frz; !clk_en |=> $stable(sink_on) && $stable(reg_rdata); endproperty
	a_frz: assert property (p_frz) else $error("frozen");
endmodule : lsbc_sva
bind lsbc_top lsbc_sva #(.TICK_CYCLES(TICK_CYCLES)) chk
(
	.clk                (clk),
	.sys_rst            (sys_rst),
	.clk_en             (clk_en),
	.reg_wr             (reg_wr),
	.reg_addr           (reg_addr),
	.reg_wdata          (reg_wdata),
	.reg_rdata          (reg_rdata),
	.sink_on            (sink_on),
	.fade_law_select    (fade_law_select),
	.fade_square_dac    (fade_square_dac),
	.fade_dwell_profile (fade_dwell_profile)
);

// file: bench/lsbc_host.sv
// Purpose: host model on the register port
// Assumes: read data one cycle after address
// Notes: requests change just after a rising edge
`timescale 1ns/1ps
module lsbc_host
(
	input  wire logic       clk,
	input  wire logic [7:0] reg_rdata,
	output logic            clk_en = 1'b1,
	output logic            reg_wr = 1'b0,
	output logic      [7:0] reg_addr = 8'h00,
	output logic      [7:0] reg_wdata = 8'h00
);
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	// clock enable is driven only from here, so it has a single driver
	task automatic gate(input logic v);
		clk_en <= v;
	endtask : gate
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		@(posedge clk);
		#1 d = reg_rdata;
	endtask : rd
endmodule : lsbc_host

// file: bench/testbench.sv
// Purpose: self-checking bench for lsbc_top
// Assumes: TICK_CYCLES of 10
// Notes: spans are ticks times 10 clocks
`timescale 1ns/1ps
module testbench;
	import lsbc_pkg::*;
	logic         clk = 1'b0;
	logic         sys_rst = 1'b1;
	wire logic    clk_en, reg_wr;
	wire logic [7:0] reg_addr, reg_wdata;
	logic   [7:0] reg_rdata, d;
	logic   [6:0] sink_on;
	lsbc_law_type fade_law_select;
	logic         fade_square_dac;
	logic   [1:0] fade_dwell_profile;
	int           err_total = 0, check_count = 0;
	initial forever #20 clk = ~clk;
	lsbc_top #(.TICK_CYCLES(10)) uut (.clk, .sys_rst, .clk_en, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
		.sink_on, .fade_law_select, .fade_square_dac, .fade_dwell_profile);
	lsbc_host h (.clk, .reg_rdata, .clk_en, .reg_wr, .reg_addr, .reg_wdata);
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		err_total += int'(got !== exp);
		if (got !== exp) $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
	endtask : cmp
	task automatic cmp_cnt(input int got, input int exp);
		check_count++;
		err_total += int'(got != exp);
		if (got != exp) $display("CHECK FAILED %0t count %0d exp %0d", $time, got, exp);
	endtask : cmp_cnt
	task automatic complete_run(input int lost);
		err_total += lost;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run
	// sync to a fall, then time one off phase and one on phase
	task automatic meas(input int b, input int off_n, input int on_n);
		int n;
		for (int p = 0; p < 4; p++)
		begin
			for (n = 0; sink_on[b] !== !p[0] && n < 400; n++) @(posedge clk) #1;
			if (n == 400) complete_run(1);
			if (p > 1) cmp_cnt(n, p == 2 ? off_n : on_n);
		end
	endtask : meas
	task automatic t_regs;
		for (int i = 0; i < 4; i++)
		begin
			h.wr(8'h0F, 8'hFC + 8'(i));
			h.rd(8'h0F, d);
			cmp(d, 8'(i));
			cmp(8'(fade_law_select), 8'(i));
			cmp(8'(fade_square_dac), 8'(i > 0));
			cmp(8'(fade_dwell_profile), 8'(i > 1 ? i : 0));
		end
		h.wr(8'h0E, 8'h00);
		h.rd(8'h0F, d);
		cmp(d, 8'h03);
		h.wr(8'h10, 8'hFF);
		h.rd(8'h10, d);
		cmp(d, 8'h7F);
		$display("regs done");
	endtask : t_regs
	task automatic t_steady;
		repeat (150) @(posedge clk);
		#1 cmp(8'(sink_on), 8'h7F);
		h.wr(8'h10, 8'h55);
		repeat (2) @(posedge clk);
		#1 cmp(8'(sink_on), 8'h55);
		$display("steady done");
	endtask : t_steady
	task automatic t_blink;
		h.wr(8'h12, 8'h83);
		h.wr(8'h10, 8'h49);
		for (int i = 0; i < 4; i++)
		begin
			h.wr(8'h11, 8'h10 + 8'(i * 64));
			meas(6, 60, i == 0 ? 20 : i == 1 ? 60 : i * 40);
		end
		meas(0, 180, 120);
		meas(3, 120, 120);
		h.wr(8'h11, 8'hCE);
		h.wr(8'h10, 8'h70);
		meas(4, 120, 120);
		meas(5, 180, 120);
		#1 cmp(8'(sink_on[6]), 8'h01);
		$display("blink done");
	endtask : t_blink
	// reset must act while the clock enable is low
	task automatic t_halt;
		logic [7:0] v;
		@(posedge clk);
		h.gate(1'b0);
		@(posedge clk);
		#1 v = 8'(sink_on);
		repeat (200) @(posedge clk);
		sys_rst <= 1'b1;
		#1 cmp(8'(sink_on), v);
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		h.gate(1'b1);
		#1 cmp(8'(sink_on), 8'h00);
		h.rd(8'h10, d);
		cmp(d, 8'h00);
		$display("halt done");
	endtask : t_halt
	initial
	begin
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		t_regs();
		t_steady();
		t_blink();
		t_halt();
		complete_run(0);
	end
endmodule : testbench
